// ### tb/eld_loopback_assertions.sv
// Port checker of the loopback block
// Assumes loop mode changes only by Wishbone write of offset 00h
`timescale 1ns/1ps
module eld_loopback_assertions (
    input wire clk_i,
    input wire rst_n_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    input wire tx_byte_vld_i,
    input wire [7:0] tx_byte_i,
    input wire sni_vld_o,
    input wire [7:0] sni_byte_o,
    input wire mau_vld_o,
    input wire [7:0] mau_byte_o,
    input wire mem_wr_o
);
    reg [1:0] mode_r;
    // ==========
    // Loop mode shadow
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_r <= 2'b00;
        end else if (wb_cyc_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == 8'h00) begin
            mode_r <= wb_dat_i[2:1];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    a_sni_mode: assert property (
        sni_vld_o |-> mode_r == 2'b10) else $error("serial copy out of mode");
    a_sni_copy: assert property (
        mode_r == 2'b10 && tx_byte_vld_i |=> sni_vld_o && sni_byte_o == $past(tx_byte_i))
        else $error("serial copy lost");
    a_mau_mode: assert property (
        mau_vld_o |-> mode_r == 2'b00 || mode_r == 2'b11) else $error("medium out of mode");
    a_mau_copy: assert property (
        mode_r[1] == mode_r[0] && tx_byte_vld_i |=> mau_vld_o && mau_byte_o == $past(tx_byte_i))
        else $error("medium copy lost");
    a_mem_mode: assert property (
        mem_wr_o |-> mode_r == 2'b00) else $error("store in loopback");
    a_int_quiet: assert property (
        mode_r == 2'b01 |-> !sni_vld_o && !mau_vld_o) else $error("internal loop leaks");
endmodule // eld_loopback_assertions

bind eld_loopback eld_loopback_assertions eld_loopback_assertions_inst (.*);

// ### tb/eld_medium_model.sv
// Medium side model: cable health levels and cable byte frames
// Assumes the bench calls its tasks off the clock edge or at it
`timescale 1ns/1ps
module eld_medium_model (
    input wire clk_i,
    output logic vld_o = 0,
    output logic [7:0] byte_o = 0,
    output logic last_o = 0,
    output logic link_o = 0,
    output logic coax_o = 0,
    output logic mau_o = 0,
    output logic lt_o = 0
);
    // Unrelated traffic may reach the ring in cable loop
    task send(input int n, input logic [47:0] dst);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            vld_o <= 1;
            byte_o <= (i < 6) ? dst[47 - 8 * i -: 8] : 8'($urandom);
            last_o <= (i == n - 1);
        end
        @(posedge clk_i);
        vld_o <= 0;
        last_o <= 0;
        // Idle line inverts, so a stale byte never looks valid
        byte_o <= ~byte_o;
    endtask
    task health(input logic l, c, m, t);
        {link_o, coax_o, mau_o, lt_o} <= {l, c, m, t};
    endtask
endmodule // eld_medium_model

// ### tb/ethernet_loopback_diag_test.sv
// Bench of the loopback block: registers, loop paths, ring, status codes
// Assumes the checker is bound and the medium model drives the cable side
`timescale 1ns/1ps
`include "eld_regs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end
module ethernet_loopback_diag_test;
    logic clk_i = 0, rst_n_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 0, tx_byte_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, rdat;
    logic tx_byte_vld_i = 0, tx_last_i = 0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, irq_o, cab_byte_vld_i, cab_last_i, link_ok_i, coax_ok_i, mau_present_i;
    wire link_test_en_i, sni_vld_o, mau_vld_o, mem_wr_o;
    wire [7:0] cab_byte_i, sni_byte_o, mau_byte_o, mem_byte_o;
    int n_mismatch = 0, checks = 0, mem_cnt = 0, n, p, m, c, k;
    logic [7:0] fr [0:31];
    logic [7:0] ring [0:7];
    logic [47:0] sta;
    logic [1:0] md;
    eld_loopback eld_loopback_inst (.*);
    eld_medium_model eld_medium_model_inst (.clk_i(clk_i), .vld_o(cab_byte_vld_i),
        .byte_o(cab_byte_i), .last_o(cab_last_i), .link_o(link_ok_i), .coax_o(coax_ok_i),
        .mau_o(mau_present_i), .lt_o(link_test_en_i));
    task final_report;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hf, d};
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        rdat = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (i >= 20) begin
            n_mismatch++;
            final_report;
        end
    endtask
    task frame(input int n, input logic hit);
        for (int i = 0; i < n; i++) begin
            fr[i] = (i < 6) ? sta[47 - 8 * i -: 8] ^ ((hit || i) ? 8'h00 : 8'h02) : 8'($urandom);
            @(posedge clk_i);
            {tx_byte_vld_i, tx_byte_i, tx_last_i} <= {1'b1, fr[i], i == n - 1};
        end
        @(posedge clk_i);
        {tx_byte_vld_i, tx_byte_i, tx_last_i} <= {1'b0, ~tx_byte_i, 1'b0};
        repeat (8) @(posedge clk_i);
    endtask
    task ring_chk(input int n, input logic off);
        logic [63:0] w;
        logic [7:0] known;
        p = off ? n : n + 4;
        known = off ? 8'hff : 8'h00;
        for (int i = 0; i < n; i++)
            ring[i % 8] = fr[i];
        for (int i = 0; i < 3; i++) begin
            ring[(p + i) % 8] = (i == 0) ? 8'(p) : 8'h00;
            known[(p + i) % 8] = 1'b1;
        end
        known[(n - 1) % 8] = 1'b1;
        wb(0, `ELD_FIFO_LO_OFF, 0);
        w[31:0] = rdat;
        wb(0, `ELD_FIFO_HI_OFF, 0);
        w[63:32] = rdat;
        for (int i = 0; i < 8; i++)
            if (known[i]) `CHK("ring", ring[i], w[8 * i +: 8])
    endtask
    function automatic logic [7:0] exp_tstat(input logic [1:0] md, input logic l, co, mp);
        case (md)
            `ELD_MEDIA_TP: return 8'h03;
            `ELD_MEDIA_THIN: return co ? 8'h03 : 8'h0e;
            `ELD_MEDIA_THICK: return !mp ? 8'h53 : co ? 8'h03 : 8'h0e;
            default: return (l || co) ? 8'h03 : 8'h0e;
        endcase
    endfunction
    initial forever #25 clk_i = ~clk_i;
    initial begin
        repeat (100000) @(posedge clk_i);
        n_mismatch++;
        final_report;
    end
    always @(posedge clk_i)
        mem_cnt <= mem_cnt + (mem_wr_o === 1'b1);
    initial begin
        void'($urandom(32932));
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1;
        sta = {16'($urandom), 32'($urandom)};
        wb(1, `ELD_RCFG_OFF, 0);
        wb(1, `ELD_STA_LO_OFF, sta[47:16]);
        wb(1, `ELD_STA_HI_OFF, {16'h0, sta[15:0]});
        wb(1, `ELD_DCFG_OFF, 32'h40);
        wb(0, 8'h3c, 0);
        `CHK("unmapped", 32'h0, rdat)
        for (m = 1; m < 3; m++) for (c = 0; c < 2; c++) for (k = 0; k < 2; k++) begin
            n = 8 + $urandom % 13;
            wb(1, `ELD_TCFG_OFF, 2 * m + c);
            wb(0, `ELD_TCFG_OFF, 0);
            `CHK("tcfg", 32'(2 * m + c), rdat)
            wb(1, `ELD_ISTAT_OFF, 32'hff);
            p = mem_cnt;
            frame(n, k);
            wb(0, `ELD_ISTAT_OFF, 0);
            `CHK("istat", k ? 32'h6 : 32'h2, rdat)
            `CHK("stored", p, mem_cnt)
            if (k) begin
                wb(0, `ELD_RSTAT_OFF, 0);
                if (c) `CHK("rstat", 32'h2, rdat)
                ring_chk(n, c);
            end
        end
        for (k = 0; k < 16; k++) begin
            md = k[1:0];
            n = $urandom;
            eld_medium_model_inst.health(n[0], n[1], n[2], md == `ELD_MEDIA_AUTO);
            wb(1, `ELD_MEDIA_OFF, md);
            wb(1, `ELD_TCFG_OFF, 32'h6);
            frame(12, 1);
            wb(0, `ELD_TSTAT_OFF, 0);
            `CHK("tstat", {24'h0, exp_tstat(md, n[0], n[1], n[2])}, rdat)
            wb(0, `ELD_CFG2_OFF, 0);
            if (md == `ELD_MEDIA_AUTO) `CHK("coax", !n[0], rdat[5])
            eld_medium_model_inst.send(10, sta);
        end
        wb(1, `ELD_TCFG_OFF, 0);
        wb(1, `ELD_ISTAT_OFF, 32'hff);
        wb(1, `ELD_IMASK_OFF, 32'h1);
        p = mem_cnt;
        eld_medium_model_inst.send(14, sta);
        repeat (8) @(negedge clk_i);
        `CHK("mem", p + 14, mem_cnt)
        `CHK("irq", 1'b1, irq_o)
        wb(1, `ELD_IMASK_OFF, 0);
        @(negedge clk_i);
        `CHK("irq", 1'b0, irq_o)
        wb(1, `ELD_IMASK_OFF, 1);
        wb(1, `ELD_ISTAT_OFF, 1);
        @(negedge clk_i);
        `CHK("irq", 1'b0, irq_o)
        final_report;
    end
endmodule // ethernet_loopback_diag_test

// ### verilog/eld_loopback.v
// Loopback diagnostic path selection, receive FIFO ring and status codes
// Assumes Wishbone master on clk_i, byte stream from transmit serializer,
// receive byte stream from cable side, and cable health from the medium
//
// Contract
// - Mode one loops NRZ internally, ignores cable
// - Mode two loops through serial interface only
// - Mode three transmits to cable, receives everything
// - Values 02h/04h/06h select modes one-three
// - Bit 0 set disables CRC generation
// - Receive FIFO is 8-byte wrapping ring
// - CRC on: ring ends data, CRC, counts
// - CRC off: ring ends five data, counts
// - Loopback frames never stored, no received flag
// - CRC check: bad 06h/02h, good 02h/01h
// - Address mismatch: only transmit done reported
// - Address match, CRC on, mode two: 06h
// - Thin coax cable loop: good 03h, failed 0Eh
// - Thick coax: failed 0Eh, no attachment 53h
// - Twisted pair, no link test: always 03h
// - Auto media falls back to coax, flagged
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`include "eld_regs.vh"

module eld_loopback #(
    parameter DEPTH = `ELD_FIFO_DEPTH
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output wire irq_o,
    // Transmit side: one byte per strobe, frame end with frame status
    input wire tx_byte_vld_i,
    input wire [7:0] tx_byte_i,
    input wire tx_last_i,
    // Receive side from the cable
    input wire cab_byte_vld_i,
    input wire [7:0] cab_byte_i,
    input wire cab_last_i,
    // Medium health
    input wire link_ok_i,
    input wire coax_ok_i,
    input wire mau_present_i,
    input wire link_test_en_i,
    // Medium outputs and memory store
    output reg sni_vld_o,
    output reg [7:0] sni_byte_o,
    output reg mau_vld_o,
    output reg [7:0] mau_byte_o,
    output reg mem_wr_o,
    output reg [7:0] mem_byte_o
);

// =========================================================
// Registers
reg [7:0] tcfg_r;
reg [7:0] rcfg_r;
reg [7:0] dcfg_r;
reg [7:0] istat_r;
reg [7:0] imask_r;
reg [7:0] rstat_r;
reg [7:0] tstat_r;
reg [1:0] media_r;
reg coax_r;
reg [47:0] sta_r;
reg [7:0] ring_r [0:DEPTH-1];
reg [2:0] wptr_r;
reg [15:0] cnt_r;
reg [2:0] tail_r;
reg [31:0] crc_r;
reg [3:0] crc_idx_r;
reg [47:0] da_r;
reg [3:0] pos_r;

wire [1:0] lb_mode = {tcfg_r[`ELD_TCFG_LB_HI], tcfg_r[`ELD_TCFG_LB_LO]};
wire crc_inh = tcfg_r[`ELD_TCFG_CRC_INH];
wire in_loop = (lb_mode != `ELD_LB_NORMAL);

function [31:0] crc_step;
    input [31:0] c;
    input [7:0] d;
    integer k;
    reg [31:0] x;
    begin
        x = c;
        for (k = 0; k < 8; k = k + 1) begin
            x = (x[0] ^ d[k]) ? ((x >> 1) ^ 32'hedb88320) : (x >> 1);
        end
        crc_step = x;
    end
endfunction

// =========================================================
// Receive source: looped or cable
reg rx_vld;
reg [7:0] rx_byte;
reg rx_last;
always @* begin
    case (lb_mode)
        `ELD_LB_INTERNAL, `ELD_LB_SERIAL: begin
            rx_vld = tx_byte_vld_i | (crc_idx_r != 4'h0);
            rx_byte = (crc_idx_r != 4'h0) ? crc_r[7:0] : tx_byte_i;
            rx_last = (crc_idx_r == 4'h1) || (tx_byte_vld_i && tx_last_i && crc_inh);
        end
        default: begin
            rx_vld = cab_byte_vld_i;
            rx_byte = cab_byte_i;
            rx_last = cab_last_i;
        end
    endcase
end

wire [31:0] crc_nxt = crc_step(crc_r, tx_byte_i);
wire [15:0] cnt_nxt = cnt_r + 16'h0001;
wire da_hit = (da_r == sta_r);

// =========================================================
// Transmit path, CRC append and ring
integer i;
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        sni_vld_o <= 1'b0;
        sni_byte_o <= 8'h00;
        mau_vld_o <= 1'b0;
        mau_byte_o <= 8'h00;
        mem_wr_o <= 1'b0;
        mem_byte_o <= 8'h00;
        crc_r <= 32'hffffffff;
        crc_idx_r <= 4'h0;
        wptr_r <= 3'h0;
        cnt_r <= 16'h0000;
        tail_r <= 3'h0;
        da_r <= 48'h0;
        pos_r <= 4'h0;
        for (i = 0; i < DEPTH; i = i + 1) ring_r[i] <= 8'h00;
    end else begin
        sni_vld_o <= tx_byte_vld_i && (lb_mode == `ELD_LB_SERIAL);
        sni_byte_o <= tx_byte_i;
        // Internal and serial loops keep the medium quiet
        mau_vld_o <= tx_byte_vld_i && (lb_mode[1] == lb_mode[0]);
        mau_byte_o <= tx_byte_i;
        // Whole frame is streamed out; a partly shifted address cannot gate it
        mem_wr_o <= rx_vld && !in_loop;
        mem_byte_o <= rx_byte;
        if (tx_byte_vld_i) begin
            crc_r <= crc_nxt;
            if (tx_last_i && !crc_inh)
                crc_idx_r <= 4'h4;
        end else if (crc_idx_r != 4'h0) begin
            crc_r <= {8'h00, crc_r[31:8]};
            crc_idx_r <= crc_idx_r - 4'h1;
        end
        if (tail_r != 3'h0) begin
            // Counts trail the frame: low, high, high again
            ring_r[wptr_r] <= (tail_r == 3'h3) ? cnt_r[7:0] : cnt_r[15:8];
            wptr_r <= wptr_r + 3'h1;
            tail_r <= tail_r - 3'h1;
            if (tail_r == 3'h1) begin
                cnt_r <= 16'h0000;
                crc_r <= 32'hffffffff;
                pos_r <= 4'h0;
            end
        end else if (rx_vld) begin
            if (cnt_r == 16'h0000)
                wptr_r <= 3'h1;
            else
                wptr_r <= wptr_r + 3'h1;
            ring_r[(cnt_r == 16'h0000) ? 3'h0 : wptr_r] <= rx_byte;
            cnt_r <= cnt_nxt;
            if (pos_r < 4'h6) begin
                da_r <= {da_r[39:0], rx_byte};
                pos_r <= pos_r + 4'h1;
            end
            if (rx_last)
                tail_r <= 3'h3;
        end
    end
end

// =========================================================
// Frame end status evaluation
wire frame_end = (tail_r == 3'h1);
reg [7:0] tx_code;
always @* begin
    case (media_r)
        `ELD_MEDIA_THIN: tx_code = coax_ok_i ? `ELD_TSTAT_OK : `ELD_TSTAT_ABORT;
        `ELD_MEDIA_THICK: tx_code = !mau_present_i ? `ELD_TSTAT_NOMAU :
            (coax_ok_i ? `ELD_TSTAT_OK : `ELD_TSTAT_ABORT);
        `ELD_MEDIA_AUTO: tx_code = (link_ok_i || coax_ok_i) ? `ELD_TSTAT_OK :
            `ELD_TSTAT_ABORT;
        default: tx_code = (!link_test_en_i || link_ok_i) ? `ELD_TSTAT_OK :
            `ELD_TSTAT_ABORT;
    endcase
end

wire acc = frame_end && da_hit;
// CRC enabled in a loop: appended check is not verified, frame flagged error
wire rx_err = acc && (crc_inh ? (crc_r != 32'hdebb20e3) : 1'b1);
wire [7:0] ev = {5'h0, rx_err, frame_end, acc && !in_loop};

// =========================================================
// Wishbone slave
wire wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
wire rd_en = wb_cyc_i && wb_stb_i && !wb_ack_o;
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        tcfg_r <= `ELD_TCFG_RST;
        rcfg_r <= 8'h00;
        dcfg_r <= 8'h00;
        istat_r <= 8'h00;
        imask_r <= 8'h00;
        rstat_r <= 8'h00;
        tstat_r <= 8'h00;
        media_r <= `ELD_MEDIA_TP;
        coax_r <= 1'b0;
        sta_r <= 48'h0;
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0;
    end else begin
        wb_ack_o <= rd_en;
        // Set wins over write-one-to-clear
        if (wr && wb_adr_i == `ELD_ISTAT_OFF)
            istat_r <= (istat_r & ~wb_dat_i[7:0]) | ev;
        else
            istat_r <= istat_r | ev;
        // Transmit status follows the last transmitted byte, not a receive
        if (tx_byte_vld_i && tx_last_i)
            tstat_r <= (lb_mode == `ELD_LB_CABLE) ? tx_code : `ELD_TSTAT_OK;
        if (frame_end && acc)
            rstat_r <= rx_err ? `ELD_RSTAT_CRC : `ELD_RSTAT_OK;
        if (media_r == `ELD_MEDIA_AUTO)
            coax_r <= !link_ok_i;
        else
            coax_r <= (media_r != `ELD_MEDIA_TP);
        if (wr) begin
            case (wb_adr_i)
                `ELD_TCFG_OFF: tcfg_r <= wb_dat_i[7:0];
                `ELD_RCFG_OFF: rcfg_r <= wb_dat_i[7:0];
                `ELD_DCFG_OFF: dcfg_r <= wb_dat_i[7:0];
                `ELD_IMASK_OFF: imask_r <= wb_dat_i[7:0];
                `ELD_MEDIA_OFF: media_r <= wb_dat_i[1:0];
                `ELD_STA_LO_OFF: sta_r[47:16] <= wb_dat_i;
                `ELD_STA_HI_OFF: sta_r[15:0] <= wb_dat_i[15:0];
                default: ;
            endcase
        end
        case (wb_adr_i)
            `ELD_TCFG_OFF: wb_dat_o <= {24'h0, tcfg_r};
            `ELD_RCFG_OFF: wb_dat_o <= {24'h0, rcfg_r};
            `ELD_DCFG_OFF: wb_dat_o <= {24'h0, dcfg_r};
            `ELD_ISTAT_OFF: wb_dat_o <= {24'h0, istat_r};
            `ELD_IMASK_OFF: wb_dat_o <= {24'h0, imask_r};
            `ELD_RSTAT_OFF: wb_dat_o <= {24'h0, rstat_r};
            `ELD_TSTAT_OFF: wb_dat_o <= {24'h0, tstat_r};
            `ELD_CFG2_OFF: wb_dat_o <= {26'h0, coax_r, 5'h0};
            `ELD_STA_LO_OFF: wb_dat_o <= sta_r[47:16];
            `ELD_STA_HI_OFF: wb_dat_o <= {16'h0, sta_r[15:0]};
            `ELD_FIFO_LO_OFF: wb_dat_o <= {ring_r[3], ring_r[2], ring_r[1], ring_r[0]};
            `ELD_FIFO_HI_OFF: wb_dat_o <= {ring_r[7], ring_r[6], ring_r[5], ring_r[4]};
            `ELD_MEDIA_OFF: wb_dat_o <= {30'h0, media_r};
            default: wb_dat_o <= 32'h0;
        endcase
    end
end

assign irq_o = |(istat_r & imask_r);

endmodule // eld_loopback

// ### verilog/eld_regs.vh
// Register offsets, fields, status codes and loop modes of the loopback block
// Assumes a 32-bit classic Wishbone slave with word-aligned registers
`ifndef ELD_REGS_VH
`define ELD_REGS_VH

// =========================================================
// Register byte offsets
`define ELD_TCFG_OFF 8'h00
`define ELD_RCFG_OFF 8'h04
`define ELD_DCFG_OFF 8'h08
`define ELD_ISTAT_OFF 8'h0c
`define ELD_IMASK_OFF 8'h10
`define ELD_RSTAT_OFF 8'h14
`define ELD_TSTAT_OFF 8'h18
`define ELD_CFG2_OFF 8'h1c
`define ELD_STA_LO_OFF 8'h20
`define ELD_STA_HI_OFF 8'h24
`define ELD_FIFO_LO_OFF 8'h28
`define ELD_FIFO_HI_OFF 8'h2c
`define ELD_MEDIA_OFF 8'h30

// =========================================================
// Field positions
`define ELD_TCFG_CRC_INH 0
`define ELD_TCFG_LB_LO 1
`define ELD_TCFG_LB_HI 2
`define ELD_CFG2_COAX 5
`define ELD_ISTAT_PRX 0
`define ELD_ISTAT_PTX 1
`define ELD_ISTAT_RXE 2

// =========================================================
// Loop modes and media
`define ELD_LB_NORMAL 2'b00
`define ELD_LB_INTERNAL 2'b01
`define ELD_LB_SERIAL 2'b10
`define ELD_LB_CABLE 2'b11
`define ELD_MEDIA_TP 2'h0
`define ELD_MEDIA_THIN 2'h1
`define ELD_MEDIA_THICK 2'h2
`define ELD_MEDIA_AUTO 2'h3

// =========================================================
// Status codes
`define ELD_TSTAT_OK 8'h03
`define ELD_TSTAT_ABORT 8'h0e
`define ELD_TSTAT_NOMAU 8'h53
`define ELD_RSTAT_OK 8'h01
`define ELD_RSTAT_CRC 8'h02

// =========================================================
// Reset values
`define ELD_TCFG_RST 8'h00
`define ELD_FIFO_DEPTH 8
`endif
